// >>> verilog/pps_pkg.sv
package pps_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte addresses, one 32-bit word each
   localparam logic [3:0] ADDR_STEER     = 4'h0;
   localparam logic [3:0] ADDR_CAPPWM    = 4'h4;
   localparam logic [3:0] ADDR_STATUS    = 4'h8;
   localparam logic [3:0] ADDR_SHUTDOWN  = 4'hC;

   // Steering control field layout
   localparam int STEER_EN_LSB  = 0;
   localparam int STEER_EN_W    = 4;
   localparam int STEER_SYNC_B  = 4;
   localparam logic [7:0] STEER_WMASK = 8'h1F;
   localparam logic [7:0] STEER_RESET = 8'h01;

   // Capture/PWM control field layout
   localparam int MODE_HI_LSB   = 2;
   localparam int MODE_POL_LSB  = 0;
   localparam int OUTCFG_LSB    = 6;
   localparam logic [1:0] MODE_HI_PWM   = 2'h3;
   localparam logic [1:0] OUTCFG_SINGLE = 2'h0;
   localparam logic [7:0] CAPPWM_RESET  = 8'h00;

   // Shutdown state control: two bits per pin pair
   localparam logic [1:0] SD_DRIVE0 = 2'h0;
   localparam logic [1:0] SD_DRIVE1 = 2'h1;
   localparam logic [3:0] SD_RESET  = 4'h0;

   // Pending update state
   typedef enum logic [0:0] {
      PPS_IDLE,
      PPS_PEND
   } pps_state_t;

endpackage

// >>> verilog/pps_pin_mux.sv
`timescale 1ns/1ns
// One output pin: steered waveform, shutdown state or port control
module pps_pin_mux (
   input  wire logic       i_route,
   input  wire logic       i_wave,
   input  wire logic       i_shutdown,
   input  wire logic [1:0] i_sd_state,
   input  wire logic       i_port_out,
   input  wire logic       i_port_oe_n,
   output logic            o_pin_out,
   output logic            o_pin_oe_n
);

   // Shutdown only touches pins that carry the waveform
   always_comb begin
      o_pin_out  = i_port_out;
      o_pin_oe_n = i_port_oe_n;
      if (i_route) begin
         o_pin_out  = i_wave;
         o_pin_oe_n = i_port_oe_n;
         if (i_shutdown) begin
            o_pin_out  = (i_sd_state == pps_pkg::SD_DRIVE1);
            o_pin_oe_n = i_sd_state[1] | i_port_oe_n;
         end
      end
   end

endmodule

// >>> verilog/pps_avalon_slave.sv
`timescale 1ns/1ns
// Avalon-MM slave: one wait cycle, then answer
module pps_avalon_slave (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_read,
   input  wire logic        i_write,
   input  wire logic [3:0]  i_address,
   input  wire logic [31:0] i_read_word,
   output logic             o_waitrequest,
   output logic             o_wr_strobe,
   output logic             o_rd_strobe,
   output logic [31:0]      o_readdata
);

   logic        ack;
   logic        next_ack;
   logic [31:0] next_readdata;

   // Ack rises one cycle after the request, drops after the taking edge
   always_comb begin
      next_ack      = (i_read | i_write) & ~ack;
      next_readdata = o_readdata;
      if (i_read & ~ack) begin
         next_readdata = i_read_word;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack        <= 1'b0;
         o_readdata <= 32'h0000_0000;
      end else begin
         ack        <= next_ack;
         o_readdata <= next_readdata;
      end
   end

   assign o_waitrequest = (i_read | i_write) & ~ack;
   assign o_wr_strobe   = i_write & ack;
   assign o_rd_strobe   = i_read & ack;

endmodule

// >>> verilog/pps_steering.sv
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
module pps_steering (
   input  wire logic        i_ref_clk,
   input  wire logic        i_nrst,
   // Avalon-MM register port
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [3:0]  i_avs_address,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic             o_avs_waitrequest,
   output logic [31:0]      o_avs_readdata,
   // From the PWM generator and shutdown logic
   input  wire logic        i_pwm_wave,
   input  wire logic        i_period_start,
   input  wire logic        i_shutdown,
   // Ordinary port latch and driver enables, pins a to d
   input  wire logic [3:0]  i_port_out,
   input  wire logic [3:0]  i_port_oe_n,
   output logic [3:0]       o_pwm_out,
   output logic [3:0]       o_pwm_oe_n,
   output logic [3:0]       o_steer_active
);

   ////////////////////////////////////////////////////////////////////////////
   // Reset release through two flops
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave
   logic        wr_strobe;
   logic        rd_strobe;
   logic [31:0] read_word;

   pps_avalon_slave u_slave (
      .i_clk         (i_ref_clk),
      .i_rst_n       (rst_n),
      .i_read        (i_avs_read),
      .i_write       (i_avs_write),
      .i_address     (i_avs_address),
      .i_read_word   (read_word),
      .o_waitrequest (o_avs_waitrequest),
      .o_wr_strobe   (wr_strobe),
      .o_rd_strobe   (rd_strobe),
      .o_readdata    (o_avs_readdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Register state
   logic [7:0]           steering_control_reg;
   logic [7:0]           capture_pwm_ctrl_reg;
   logic [3:0]           shutdown_state;
   logic [3:0]           active_enables;
   pps_pkg::pps_state_t  state;
   logic [7:0]           next_steering_control_reg;
   logic [7:0]           next_capture_pwm_ctrl_reg;
   logic [3:0]           next_shutdown_state;
   logic [3:0]           next_active_enables;
   pps_pkg::pps_state_t  next_state;
   logic                 wr_lane0;
   logic [3:0]           new_enables;
   logic                 steer_update_sync;

   assign wr_lane0          = wr_strobe & i_avs_byteenable[0];
   assign new_enables       = i_avs_writedata[pps_pkg::STEER_EN_LSB +: pps_pkg::STEER_EN_W];
   assign steer_update_sync = steering_control_reg[pps_pkg::STEER_SYNC_B];

   // Register writes and routing update
   always_comb begin
      next_steering_control_reg = steering_control_reg;
      next_capture_pwm_ctrl_reg = capture_pwm_ctrl_reg;
      next_shutdown_state       = shutdown_state;
      next_active_enables       = active_enables;
      next_state                = state;
      if (wr_lane0) begin
         case (i_avs_address)
            pps_pkg::ADDR_STEER: begin
               // Unimplemented upper bits dropped on write
               next_steering_control_reg = i_avs_writedata[7:0] & pps_pkg::STEER_WMASK;
               if (i_avs_writedata[pps_pkg::STEER_SYNC_B]) begin
                  next_state = pps_pkg::PPS_PEND;
               end else begin
                  next_active_enables = new_enables;
                  next_state          = pps_pkg::PPS_IDLE;
               end
            end
            pps_pkg::ADDR_CAPPWM: begin
               next_capture_pwm_ctrl_reg = i_avs_writedata[7:0];
            end
            pps_pkg::ADDR_SHUTDOWN: begin
               next_shutdown_state = i_avs_writedata[3:0];
            end
            default: begin
            end
         endcase
      end
      // Pending setting lands on the period boundary
      case (state)
         pps_pkg::PPS_PEND: begin
            if (i_period_start && !(wr_lane0 && i_avs_address == pps_pkg::ADDR_STEER)) begin
               next_active_enables = steering_control_reg[pps_pkg::STEER_EN_LSB +: pps_pkg::STEER_EN_W];
               next_state          = pps_pkg::PPS_IDLE;
            end
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         steering_control_reg <= pps_pkg::STEER_RESET;
         capture_pwm_ctrl_reg <= pps_pkg::CAPPWM_RESET;
         shutdown_state       <= pps_pkg::SD_RESET;
         active_enables       <= pps_pkg::STEER_RESET[3:0];
         state                <= pps_pkg::PPS_IDLE;
      end else begin
         steering_control_reg <= next_steering_control_reg;
         capture_pwm_ctrl_reg <= next_capture_pwm_ctrl_reg;
         shutdown_state       <= next_shutdown_state;
         active_enables       <= next_active_enables;
         state                <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read mux; status shows live routing and pending flag
   always_comb begin
      read_word = 32'h0000_0000;
      case (i_avs_address)
         pps_pkg::ADDR_STEER:    read_word[7:0] = steering_control_reg;
         pps_pkg::ADDR_CAPPWM:   read_word[7:0] = capture_pwm_ctrl_reg;
         pps_pkg::ADDR_STATUS:   read_word[4:0] = {(state == pps_pkg::PPS_PEND), o_steer_active};
         pps_pkg::ADDR_SHUTDOWN: read_word[3:0] = shutdown_state;
         default:                read_word = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode gate and polarity
   logic       single_mode;
   logic [1:0] polarity;
   logic [3:0] wave_pin;

   // Other modes leave every pin on port control
   assign single_mode = (capture_pwm_ctrl_reg[pps_pkg::MODE_HI_LSB +: 2] == pps_pkg::MODE_HI_PWM) &&
                        (capture_pwm_ctrl_reg[pps_pkg::OUTCFG_LSB +: 2] == pps_pkg::OUTCFG_SINGLE);
   assign polarity    = capture_pwm_ctrl_reg[pps_pkg::MODE_POL_LSB +: 2];
   // With no enable set no pin is routed; firmware must pick one
   assign o_steer_active = active_enables & {4{single_mode}};

   // Pair A/C uses high shutdown field, pair B/D the low one
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_pin
         // Pin a and c active-low on pol bit 1, b and d on pol bit 0
         assign wave_pin[g] = i_pwm_wave ^ ((g % 2 == 1) ? polarity[0] : polarity[1]);
         pps_pin_mux u_mux (
            .i_route     (o_steer_active[g]),
            .i_wave      (wave_pin[g]),
            .i_shutdown  (i_shutdown),
            .i_sd_state  ((g % 2 == 1) ? shutdown_state[1:0] : shutdown_state[3:2]),
            .i_port_out  (i_port_out[g]),
            .i_port_oe_n (i_port_oe_n[g]),
            .o_pin_out   (o_pwm_out[g]),
            .o_pin_oe_n  (o_pwm_oe_n[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence steer_wr_s(logic sync);
      wr_lane0 && i_avs_address == pps_pkg::ADDR_STEER && i_avs_writedata[pps_pkg::STEER_SYNC_B] == sync;
   endsequence

   immed_update_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      steer_wr_s(1'b0) |=> active_enables == $past(new_enables))
      else $error("immediate steering update missed");

   held_pending_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      steer_wr_s(1'b1) |=> state == pps_pkg::PPS_PEND && $stable(active_enables))
      else $error("synced steering applied early");

   period_apply_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      (state == pps_pkg::PPS_PEND && i_period_start && !wr_lane0) |=>
      active_enables == $past(steering_control_reg[3:0]) && state == pps_pkg::PPS_IDLE)
      else $error("pending steering not applied at period start");

   upper_zero_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      steering_control_reg[7:5] == 3'h0)
      else $error("unimplemented steering bits set");

   mode_gate_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      !single_mode |-> o_steer_active == 4'h0 && o_pwm_out == i_port_out)
      else $error("steering active outside single mode");

   pin_d_wave_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      (o_steer_active[3] && !i_shutdown) |-> o_pwm_out[3] == (i_pwm_wave ^ polarity[0]))
      else $error("pin d waveform wrong");

   pin_c_wave_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      (o_steer_active[2] && !i_shutdown) |-> o_pwm_out[2] == (i_pwm_wave ^ polarity[1]))
      else $error("pin c waveform wrong");

   pin_b_port_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      !o_steer_active[1] |-> o_pwm_out[1] == i_port_out[1] && o_pwm_oe_n[1] == i_port_oe_n[1])
      else $error("pin b not on port control");

   pin_a_port_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      !o_steer_active[0] |-> o_pwm_out[0] == i_port_out[0])
      else $error("pin a not on port control");

   shutdown_scope_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      (i_shutdown && !o_steer_active[3]) |-> o_pwm_out[3] == i_port_out[3])
      else $error("shutdown hit unrouted pin");

   pin_b_wave_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      (o_steer_active[1] && !i_shutdown) |-> o_pwm_out[1] == (i_pwm_wave ^ polarity[0]))
      else $error("pin b waveform wrong");

   pin_a_wave_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      (o_steer_active[0] && !i_shutdown) |-> o_pwm_out[0] == (i_pwm_wave ^ polarity[1]))
      else $error("pin a waveform wrong");

   pin_c_port_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      !o_steer_active[2] |-> o_pwm_out[2] == i_port_out[2] && o_pwm_oe_n[2] == i_port_oe_n[2])
      else $error("pin c not on port control");

   pin_d_port_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      !o_steer_active[3] |-> o_pwm_out[3] == i_port_out[3] && o_pwm_oe_n[3] == i_port_oe_n[3])
      else $error("pin d not on port control");

   // Outside shutdown the driver enables always stay with the port
   routed_oe_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      !i_shutdown |-> o_pwm_oe_n == i_port_oe_n)
      else $error("pin enable changed without shutdown");

   shutdown_ac_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      (i_shutdown && o_steer_active[0]) |-> o_pwm_out[0] == (shutdown_state[3:2] == pps_pkg::SD_DRIVE1) &&
      o_pwm_oe_n[0] == (shutdown_state[3] | i_port_oe_n[0]))
      else $error("pin a shutdown state wrong");

   shutdown_bd_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      (i_shutdown && o_steer_active[1]) |-> o_pwm_out[1] == (shutdown_state[1:0] == pps_pkg::SD_DRIVE1) &&
      o_pwm_oe_n[1] == (shutdown_state[1] | i_port_oe_n[1]))
      else $error("pin b shutdown state wrong");

   ////////////////////////////////////////////////////////////////////////////
   // Register and update ordering checks
   sequence sync_hold_s;
      steer_wr_s(1'b1) ##1 !i_period_start;
   endsequence

   sequence req_start_s;
      (i_avs_read || i_avs_write) && o_avs_waitrequest;
   endsequence

   sync0_idle_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      steer_wr_s(1'b0) |=> state == pps_pkg::PPS_IDLE)
      else $error("immediate write left update pending");

   // No strobe in the cycle after a take, so nothing can apply here
   sync_hold_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      sync_hold_s |=> state == pps_pkg::PPS_PEND && $stable(active_enables))
      else $error("synced steering applied without period start");

   idle_hold_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      (state == pps_pkg::PPS_IDLE && !(wr_lane0 && i_avs_address == pps_pkg::ADDR_STEER)) |=>
      $stable(active_enables))
      else $error("routing changed without update");

   cap_write_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      (wr_lane0 && i_avs_address == pps_pkg::ADDR_CAPPWM) |=> capture_pwm_ctrl_reg == $past(i_avs_writedata[7:0]))
      else $error("mode register write lost");

   // Read data is captured while the address still stands
   steer_read_zero_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      (rd_strobe && i_avs_address == pps_pkg::ADDR_STEER) |-> o_avs_readdata[31:5] == 27'h0)
      else $error("unimplemented steering bits read back");

   one_wait_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      req_start_s |=> !o_avs_waitrequest)
      else $error("bus answer later than one wait cycle");

endmodule

// >>> dv/pps_load_model.sv
`timescale 1ns/1ns
// Load on the four pins; a weak pull-down holds a released pin low
module pps_load_model (
   input  wire logic [3:0] i_pin_out,
   input  wire logic [3:0] i_pin_oe_n,
   output logic [3:0]      o_level
);
   // Released pin shows the pull-down level, never the last driven value
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         o_level[i] = i_pin_oe_n[i] ? 1'b0 : i_pin_out[i];
      end
   end
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   logic        clk = 1'b0, nrst = 1'b0, rd = 1'b0, wr = 1'b0;
   logic        wave = 1'b0, ps = 1'b0, sd = 1'b0, waitreq;
   logic [3:0]  addr = 4'h0, be = 4'hF, pout = 4'h0, poe_n = 4'hF;
   logic [3:0]  pin_out, pin_oe_n, steer_act, level;
   logic [31:0] wdata = 32'h0, rdata;
   int          n_fail = 0, checks_done = 0, seed = 61, cycles = 0;
   // Reference state, updated at the same edges as the design
   logic [7:0]  m_cap = 8'h00;
   logic [3:0]  m_sd = 4'h0, m_act = 4'h1;
   // Pending synced setting; at most one entry, a later write replaces it
   logic [3:0]  m_pnd_q[$];

   always #2 clk = ~clk;

   pps_steering DUT (
      .i_ref_clk        (clk),
      .i_nrst           (nrst),
      .i_avs_read       (rd),
      .i_avs_write      (wr),
      .i_avs_address    (addr),
      .i_avs_writedata  (wdata),
      .i_avs_byteenable (be),
      .o_avs_waitrequest(waitreq),
      .o_avs_readdata   (rdata),
      .i_pwm_wave       (wave),
      .i_period_start   (ps),
      .i_shutdown       (sd),
      .i_port_out       (pout),
      .i_port_oe_n      (poe_n),
      .o_pwm_out        (pin_out),
      .o_pwm_oe_n       (pin_oe_n),
      .o_steer_active   (steer_act)
   );

   pps_load_model load (
      .i_pin_out (pin_out),
      .i_pin_oe_n(pin_oe_n),
      .o_level   (level)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      if (n_fail == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk_rd(input string name, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic chk_pin(input string name, input logic [3:0] e, input logic [3:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", name, e, g);
      end
   endtask

   // Hang guard: the whole sequence needs about a thousand cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail++;
         conclude();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // One Avalon-MM transfer; held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] b,
                      output logic [31:0] q);
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= {24'($random(seed)), d};
      be <= b;
      // Values read right after the edge are those the design sampled there
      @(posedge clk);
      while (waitreq !== 1'b0) begin
         @(posedge clk);
      end
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (w && b[0]) begin
         case (a)
            pps_pkg::ADDR_STEER: begin
               m_pnd_q.delete();
               if (d[pps_pkg::STEER_SYNC_B]) begin
                  m_pnd_q.push_back(d[3:0]);
               end else begin
                  m_act = d[3:0];
               end
            end
            pps_pkg::ADDR_CAPPWM: m_cap = d;
            pps_pkg::ADDR_SHUTDOWN: m_sd = d[3:0];
            default: ;
         endcase
      end
   endtask

   // Pin expectations from mode gate, polarity, shutdown pair states
   task automatic check_pins();
      logic [3:0] e_oe, e_lv, act;
      logic [1:0] st;
      logic       v;
      act = (m_cap[3:2] == pps_pkg::MODE_HI_PWM && m_cap[7:6] == pps_pkg::OUTCFG_SINGLE) ? m_act : 4'h0;
      for (int i = 0; i < 4; i++) begin
         st = i[0] ? m_sd[1:0] : m_sd[3:2];
         v = act[i] ? (wave ^ (i[0] ? m_cap[0] : m_cap[1])) : pout[i];
         e_oe[i] = poe_n[i];
         if (act[i] && sd) begin
            v = st[0];
            e_oe[i] = st[1] | poe_n[i];
         end
         e_lv[i] = e_oe[i] ? 1'b0 : v;
      end
      chk_pin("steer_active", act, steer_act);
      chk_pin("pin_oe_n", e_oe, pin_oe_n);
      chk_pin("pin_level", e_lv, level);
   endtask

   // One pin cycle with random wave, shutdown and port inputs
   task automatic cyc(input logic p);
      @(posedge clk);
      if (ps === 1'b1 && m_pnd_q.size() > 0) begin
         m_act = m_pnd_q.pop_front();
      end
      wave <= 1'($random(seed));
      sd <= 1'($random(seed));
      pout <= 4'($random(seed));
      poe_n <= 4'($random(seed));
      ps <= p;
      @(negedge clk);
      check_pins();
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] q;
      logic [7:0]  d;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      repeat (5) @(posedge clk);
      // Reset values, unmapped place, dropped writes
      bus(0, pps_pkg::ADDR_STEER, 8'h00, 4'hF, q); chk_rd("steer_rst", 32'h01, q);
      bus(0, pps_pkg::ADDR_CAPPWM, 8'h00, 4'hF, q); chk_rd("cap_rst", 32'h00, q);
      bus(0, pps_pkg::ADDR_SHUTDOWN, 8'h00, 4'hF, q); chk_rd("sd_rst", 32'h00, q);
      bus(0, 4'h2, 8'h00, 4'hF, q); chk_rd("unmapped", 32'h00, q);
      repeat (4) cyc(1'b0);
      bus(1, pps_pkg::ADDR_STEER, 8'hEA, 4'hE, q);
      bus(0, pps_pkg::ADDR_STEER, 8'h00, 4'hF, q); chk_rd("steer_be", 32'h01, q);
      bus(1, pps_pkg::ADDR_STEER, 8'hEA, 4'hF, q);
      bus(0, pps_pkg::ADDR_STEER, 8'h00, 4'hF, q); chk_rd("steer_unimp", 32'h0A, q);
      // Every enable pattern, then random settings with either sync choice
      for (int k = 0; k < 48; k++) begin
         d = 8'($random(seed));
         if (k % 4 != 0) begin
            d[7:6] = pps_pkg::OUTCFG_SINGLE;
            d[3:2] = pps_pkg::MODE_HI_PWM;
         end
         bus(1, pps_pkg::ADDR_CAPPWM, d, 4'hF, q);
         bus(1, pps_pkg::ADDR_SHUTDOWN, 8'($random(seed)), 4'hF, q);
         d = (k < 16) ? 8'(k) : 8'($random(seed));
         bus(1, pps_pkg::ADDR_STEER, d, 4'hF, q);
         repeat (3) cyc(1'b0);
         bus(0, pps_pkg::ADDR_STEER, 8'h00, 4'hF, q); chk_rd("steer", {24'h0, d & pps_pkg::STEER_WMASK}, q);
         if (k % 4 != 0) begin
            bus(0, pps_pkg::ADDR_STATUS, 8'h00, 4'hF, q);
            chk_rd("status", {27'h0, (m_pnd_q.size() > 0), m_act}, q);
         end
         cyc(1'b1);
         repeat (3) cyc(1'b0);
      end
      conclude();
   end
endmodule
